/* core/ccs_pkg.sv */
// Shared constants, field layouts and types of the charger control and status registers
package ccs_pkg;

  // Register addresses on the register access port
  localparam logic [7:0] ADDR_MISC_CTRL = 8'h07;
  localparam logic [7:0] ADDR_SYS_STAT  = 8'h08;
  localparam logic [7:0] RDATA_NONE     = 8'h00;

  // Timing
  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned BSW_OFF_DELAY_S   = 10;
  localparam int unsigned BSW_OFF_DELAY_CYC = BSW_OFF_DELAY_S * CLK_HZ;
  localparam int          CNT_W             = 29;

  // Voltages in millivolts
  localparam int          MV_W        = 13;
  localparam logic [12:0] TRK_MV_NONE = 13'h0000;
  localparam logic [12:0] TRK_MV_200  = 13'h00c8;
  localparam logic [12:0] TRK_MV_250  = 13'h00fa;
  localparam logic [12:0] TRK_MV_300  = 13'h012c;
  localparam logic [12:0] WARM_CAP_MV = 13'h1004;

  // Floor tracking codes
  localparam logic [1:0] TRK_OFF = 2'h0;
  localparam logic [1:0] TRK_200 = 2'h1;
  localparam logic [1:0] TRK_250 = 2'h2;

  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic       force_source_detect;
    logic       slow_safety_timer_en;
    logic       battery_switch_off;
    logic       warm_charge_voltage_sel;
    logic       battery_switch_off_delay;
    logic       battery_switch_reset_en;
    logic [1:0] floor_tracking_offset;
  } ccs_ctrl_t;

  localparam logic [7:0] CTRL_RESET     = 8'h4c;
  // Fields that a watchdog expiry also restores
  localparam logic [7:0] CTRL_WDOG_MASK = 8'hd4;

  // Input source codes
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_SDP  = 3'h1;
  localparam logic [2:0] SRC_ADPT = 3'h2;
  localparam logic [2:0] SRC_OTG  = 3'h7;

  // Status register, bit 7 down to bit 0
  typedef struct packed {
    logic [2:0] input_source_status;
    logic [1:0] charge_phase_status;
    logic       power_good_flag;
    logic       thermal_reg_flag;
    logic       min_system_reg_flag;
  } ccs_stat_t;

  typedef enum logic [1:0] {
    BSW_ON   = 2'b00,
    BSW_WAIT = 2'b01,
    BSW_OFF  = 2'b11
  } ccs_bsw_state_t;

endpackage

/* core/ccs_switch_timer.sv */
// Battery switch turn-off sequencer with optional delay
`timescale 1ns/1ps
`default_nettype none
module ccs_switch_timer #(
  parameter int unsigned DELAY_CYCLES = ccs_pkg::BSW_OFF_DELAY_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic off_req,
  input  wire logic use_delay,
  output var  logic switch_on_r
);

  localparam logic [ccs_pkg::CNT_W-1:0] LAST = ccs_pkg::CNT_W'(DELAY_CYCLES - 1);

  ccs_pkg::ccs_bsw_state_t      state_r;
  ccs_pkg::ccs_bsw_state_t      state_nxt;
  logic [ccs_pkg::CNT_W-1:0]    cnt_r;
  logic [ccs_pkg::CNT_W-1:0]    cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ccs_pkg::BSW_ON: begin
        if (off_req) begin
          state_nxt = use_delay ? ccs_pkg::BSW_WAIT : ccs_pkg::BSW_OFF;
        end
      end
      ccs_pkg::BSW_WAIT: begin
        if (!off_req) begin
          state_nxt = ccs_pkg::BSW_ON;
        end else if (cnt_r == LAST) begin
          state_nxt = ccs_pkg::BSW_OFF;
        end
      end
      ccs_pkg::BSW_OFF: begin
        if (!off_req) begin
          state_nxt = ccs_pkg::BSW_ON;
        end
      end
      default: state_nxt = ccs_pkg::BSW_ON;
    endcase
  end

  assign cnt_nxt = (state_r == ccs_pkg::BSW_WAIT) ? cnt_r + 1'b1 : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ccs_pkg::BSW_ON;
      cnt_r       <= '0;
      switch_on_r <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      switch_on_r <= (state_nxt != ccs_pkg::BSW_OFF);
    end
  end

  property p_no_early_off;
    @(posedge clk) disable iff (!rst_n)
      (state_r == ccs_pkg::BSW_WAIT && off_req && cnt_r != LAST) |=> switch_on_r;
  endproperty
  a_no_early_off: assert property (p_no_early_off)
    else $error("Battery switch turned off before delay ran out");

  property p_wait_ends_off;
    @(posedge clk) disable iff (!rst_n)
      (state_r == ccs_pkg::BSW_WAIT && off_req && cnt_r == LAST) |=> !switch_on_r;
  endproperty
  a_wait_ends_off: assert property (p_wait_ends_off)
    else $error("Battery switch still on after delay");

endmodule
`default_nettype wire

/* core/ccs_regs.sv */
// Charger control and status register pair with battery switch and floor logic
`timescale 1ns/1ps
`default_nettype none
module ccs_regs #(
  parameter int unsigned OFF_DELAY_CYCLES = ccs_pkg::BSW_OFF_DELAY_CYC
) (
  input  wire logic                     CLK_SYS,
  input  wire logic                     RSTN,
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  input  wire logic [7:0]               REG_ADDR,
  input  wire logic [7:0]               REG_WDATA,
  output var  logic [7:0]               REG_RDATA,
  input  wire logic                     REG_RESET_CMD,
  input  wire logic                     WATCHDOG_EXPIRED,
  input  wire logic                     VARIANT_PSEL,
  input  wire logic                     PSEL_PIN,
  input  wire logic                     VBUS_PRESENT,
  input  wire logic                     OTG_MODE,
  input  wire logic [2:0]               DETECT_RESULT,
  input  wire logic                     DETECT_DONE,
  output var  logic                     DETECT_START,
  input  wire logic [1:0]               CHARGE_PHASE,
  input  wire logic                     POWER_GOOD,
  input  wire logic                     THERMAL_REG,
  input  wire logic                     VBAT_BELOW_MINSYS,
  input  wire logic                     INPUT_LIMIT_ACTIVE,
  input  wire logic                     COOL_TEMP,
  input  wire logic                     WARM_TEMP,
  input  wire logic                     TIMER_TICK_IN,
  output var  logic                     SAFETY_TIMER_TICK,
  output var  logic                     SAFETY_TIMER_CLEAR,
  output logic                          BATTERY_SWITCH_ON,
  output logic                          BATTERY_SWITCH_RESET_EN,
  input  wire logic [ccs_pkg::MV_W-1:0] VBAT_MV,
  input  wire logic [ccs_pkg::MV_W-1:0] ABS_FLOOR_MV,
  input  wire logic [ccs_pkg::MV_W-1:0] CHARGE_SETTING_MV,
  output var  logic [ccs_pkg::MV_W-1:0] EFFECTIVE_FLOOR_MV,
  output var  logic [ccs_pkg::MV_W-1:0] CHARGE_VOLTAGE_MV
);

  function automatic logic [ccs_pkg::MV_W-1:0] ccs_max(input logic [ccs_pkg::MV_W-1:0] a,
                                                       input logic [ccs_pkg::MV_W-1:0] b);
    ccs_max = (a > b) ? a : b;
  endfunction

  function automatic logic [ccs_pkg::MV_W-1:0] ccs_min(input logic [ccs_pkg::MV_W-1:0] a,
                                                       input logic [ccs_pkg::MV_W-1:0] b);
    ccs_min = (a < b) ? a : b;
  endfunction

  logic                     rst_meta_r;
  logic                     rst_n_s;
  ccs_pkg::ccs_ctrl_t       ctrl_r;
  ccs_pkg::ccs_ctrl_t       ctrl_nxt;
  ccs_pkg::ccs_stat_t       stat;
  logic                     wr_ctrl;
  logic                     rd_ctrl_sel;
  logic                     rd_stat_sel;
  logic [7:0]               ctrl_rd_val;
  logic [7:0]               rdata_nxt;
  logic [2:0]               src_code;
  logic [ccs_pkg::MV_W-1:0] trk_mv;
  logic [ccs_pkg::MV_W-1:0] trk_floor;
  logic                     slow_cond;
  logic                     half_r;

  // Reset released through two flops
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_r <= 1'b0;
      rst_n_s    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_s    <= rst_meta_r;
    end
  end

  assign wr_ctrl     = REG_WR && (REG_ADDR == ccs_pkg::ADDR_MISC_CTRL);
  assign rd_ctrl_sel = (REG_ADDR == ccs_pkg::ADDR_MISC_CTRL);
  assign rd_stat_sel = (REG_ADDR == ccs_pkg::ADDR_SYS_STAT);

  // Host write beats detection-done clear in the same cycle
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (REG_RESET_CMD) begin
      ctrl_nxt = ccs_pkg::CTRL_RESET;
    end else begin
      if (WATCHDOG_EXPIRED) begin
        ctrl_nxt = (ctrl_r & ~ccs_pkg::CTRL_WDOG_MASK)
                 | (ccs_pkg::CTRL_RESET & ccs_pkg::CTRL_WDOG_MASK);
      end
      if (DETECT_DONE) begin
        ctrl_nxt.force_source_detect = 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_nxt = REG_WDATA;
      end
    end
  end

  // Source code carries only the port type; current limit lives elsewhere
  assign src_code = OTG_MODE      ? ccs_pkg::SRC_OTG :
                    !VBUS_PRESENT ? ccs_pkg::SRC_NONE :
                    !VARIANT_PSEL ? DETECT_RESULT :
                    PSEL_PIN      ? ccs_pkg::SRC_SDP :
                                    ccs_pkg::SRC_ADPT;

  assign stat.input_source_status = src_code;
  assign stat.charge_phase_status = CHARGE_PHASE;
  assign stat.power_good_flag     = POWER_GOOD;
  assign stat.thermal_reg_flag    = THERMAL_REG;
  assign stat.min_system_reg_flag = VBAT_BELOW_MINSYS;

  assign ctrl_rd_val = {(VARIANT_PSEL ? PSEL_PIN : ctrl_r.force_source_detect),
                        ctrl_r[6:0]};
  // Status has no write path at all
  assign rdata_nxt = rd_ctrl_sel ? ctrl_rd_val :
                     rd_stat_sel ? stat :
                                   ccs_pkg::RDATA_NONE;

  assign trk_mv = (ctrl_r.floor_tracking_offset == ccs_pkg::TRK_OFF) ? ccs_pkg::TRK_MV_NONE :
                  (ctrl_r.floor_tracking_offset == ccs_pkg::TRK_200) ? ccs_pkg::TRK_MV_200 :
                  (ctrl_r.floor_tracking_offset == ccs_pkg::TRK_250) ? ccs_pkg::TRK_MV_250 :
                                                                       ccs_pkg::TRK_MV_300;
  // No saturation: battery plus offset must stay below the field range
  assign trk_floor = ccs_pkg::MV_W'(VBAT_MV + trk_mv);

  assign slow_cond = ctrl_r.slow_safety_timer_en
                   && (INPUT_LIMIT_ACTIVE || COOL_TEMP || THERMAL_REG);

  assign BATTERY_SWITCH_RESET_EN = ctrl_r.battery_switch_reset_en;

  always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ctrl_r             <= ccs_pkg::CTRL_RESET;
      REG_RDATA          <= ccs_pkg::RDATA_NONE;
      DETECT_START       <= 1'b0;
      SAFETY_TIMER_CLEAR <= 1'b0;
      SAFETY_TIMER_TICK  <= 1'b0;
      half_r             <= 1'b0;
      EFFECTIVE_FLOOR_MV <= '0;
      CHARGE_VOLTAGE_MV  <= '0;
    end else begin
      ctrl_r             <= ctrl_nxt;
      DETECT_START       <= wr_ctrl && REG_WDATA[7] && !REG_RESET_CMD;
      SAFETY_TIMER_CLEAR <= REG_RESET_CMD;
      SAFETY_TIMER_TICK  <= TIMER_TICK_IN && (!slow_cond || half_r);
      if (TIMER_TICK_IN) begin
        half_r <= slow_cond && !half_r;
      end
      if (REG_RD) begin
        REG_RDATA <= rdata_nxt;
      end
      EFFECTIVE_FLOOR_MV <= (ctrl_r.floor_tracking_offset == ccs_pkg::TRK_OFF) ? ABS_FLOOR_MV :
                            ccs_max(ABS_FLOOR_MV, trk_floor);
      CHARGE_VOLTAGE_MV  <= (WARM_TEMP && !ctrl_r.warm_charge_voltage_sel) ?
                            ccs_min(CHARGE_SETTING_MV, ccs_pkg::WARM_CAP_MV) :
                            CHARGE_SETTING_MV;
    end
  end

  ccs_switch_timer #(
    .DELAY_CYCLES (OFF_DELAY_CYCLES)
  ) u_switch_timer (
    .clk         (CLK_SYS),
    .rst_n       (rst_n_s),
    .off_req     (ctrl_r.battery_switch_off),
    .use_delay   (ctrl_r.battery_switch_off_delay),
    .switch_on_r (BATTERY_SWITCH_ON)
  );

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n_s);

  property p_detect_start;
    (wr_ctrl && REG_WDATA[7] && !REG_RESET_CMD) |=> DETECT_START && ctrl_r.force_source_detect;
  endproperty
  a_detect_start: assert property (p_detect_start)
    else $error("Detection not started by write");

  property p_psel_read;
    (REG_RD && rd_ctrl_sel && VARIANT_PSEL) |=> (REG_RDATA[7] == $past(PSEL_PIN));
  endproperty
  a_psel_read: assert property (p_psel_read)
    else $error("Detect bit read does not show select pin");

  property p_slow_tick;
    (slow_cond && TIMER_TICK_IN) [*2] |=> !(SAFETY_TIMER_TICK && $past(SAFETY_TIMER_TICK));
  endproperty
  a_slow_tick: assert property (p_slow_tick)
    else $error("Safety timer not halved");

  property p_full_tick;
    (!slow_cond && TIMER_TICK_IN) |=> SAFETY_TIMER_TICK;
  endproperty
  a_full_tick: assert property (p_full_tick)
    else $error("Safety timer tick dropped at full rate");

  property p_off_now;
    ($rose(ctrl_r.battery_switch_off) && !ctrl_r.battery_switch_off_delay) |=> !BATTERY_SWITCH_ON;
  endproperty
  a_off_now: assert property (p_off_now)
    else $error("Immediate battery switch off failed");

  property p_allow_on;
    !ctrl_r.battery_switch_off |=> BATTERY_SWITCH_ON;
  endproperty
  a_allow_on: assert property (p_allow_on)
    else $error("Battery switch held off while allowed");

  property p_warm_cap;
    (WARM_TEMP && !ctrl_r.warm_charge_voltage_sel) |=> (CHARGE_VOLTAGE_MV <= ccs_pkg::WARM_CAP_MV);
  endproperty
  a_warm_cap: assert property (p_warm_cap)
    else $error("Warm charge voltage above cap");

  property p_floor_max;
    1'b1 |=> (EFFECTIVE_FLOOR_MV >= $past(ABS_FLOOR_MV))
          && (($past(ctrl_r.floor_tracking_offset) == ccs_pkg::TRK_OFF)
              || (EFFECTIVE_FLOOR_MV >= $past(trk_floor)));
  endproperty
  a_floor_max: assert property (p_floor_max)
    else $error("Effective floor below a bound");

  property p_reg_reset;
    REG_RESET_CMD |=> (ctrl_r == ccs_pkg::CTRL_RESET) && SAFETY_TIMER_CLEAR;
  endproperty
  a_reg_reset: assert property (p_reg_reset)
    else $error("Register reset did not restore defaults");

  property p_stat_read;
    (REG_RD && rd_stat_sel) |=> (REG_RDATA == $past(stat));
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("Status read mismatch");

  property p_otg_code;
    (REG_RD && rd_stat_sel && OTG_MODE) |=> (REG_RDATA[7:5] == ccs_pkg::SRC_OTG);
  endproperty
  a_otg_code: assert property (p_otg_code)
    else $error("OTG source code wrong");

  c_delayed_off: cover property ($rose(ctrl_r.battery_switch_off) && ctrl_r.battery_switch_off_delay);
  c_slow_timer:  cover property (slow_cond && TIMER_TICK_IN ##1 slow_cond && TIMER_TICK_IN);
  c_detect:      cover property (DETECT_START ##[1:20] DETECT_DONE);
  c_reg_reset:   cover property (REG_RESET_CMD);

endmodule
`default_nettype wire

/* tb/ccs_host.sv */
// Register bus host model issuing single-byte writes and reads
`timescale 1ns/1ps
`default_nettype none
module ccs_host (
  input  wire logic       clk,
  output var  logic       wr,
  output var  logic       rd,
  output var  logic [7:0] addr,
  output var  logic [7:0] wdata,
  input  wire logic [7:0] rdata
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'hff;
    wdata = 8'h00;
  end
  // Idle bus shows inverted values so stale data never looks fresh
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #2;
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #2;
    rd = 1'b1;
    addr = a;
    @(posedge clk);
    #2;
    rd = 1'b0;
    addr = ~a;
    @(posedge clk);
    #2;
    d = rdata;
  endtask
endmodule
`default_nettype wire

/* tb/ccs_regs_tb.sv */
// Self-checking bench for the charger control and status registers
`timescale 1ns/1ps
`default_nettype none
module ccs_regs_tb;
  localparam logic [7:0] CA = ccs_pkg::ADDR_MISC_CTRL;
  localparam logic [7:0] SA = ccs_pkg::ADDR_SYS_STAT;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cmd = 1'b0;
  logic        wdog = 1'b0;
  logic        pv = 1'b0;
  logic        pin = 1'b0;
  logic        vbus = 1'b1;
  logic        otg = 1'b0;
  logic [2:0]  dres = 3'h0;
  logic        ddone = 1'b0;
  logic [1:0]  phase = 2'h0;
  logic        pg = 1'b0;
  logic        therm = 1'b0;
  logic        minsys = 1'b0;
  logic        lim = 1'b0;
  logic        cool = 1'b0;
  logic        warm = 1'b0;
  logic        tick = 1'b0;
  logic [12:0] vbat = 13'h0000;
  logic [12:0] absf = 13'h0000;
  logic [12:0] chs = 13'h0000;
  logic        wr, rd, dstart, ttick, tclr, swon, rsten;
  logic [7:0]  addr, wdata, rdata, rv, c;
  logic [12:0] floor_mv, chv;
  int          fails = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          tcnt = 0;
  int          n;

  ccs_regs #(.OFF_DELAY_CYCLES(20)) dut (
    .CLK_SYS(clk), .RSTN(rstn), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RESET_CMD(cmd), .WATCHDOG_EXPIRED(wdog),
    .VARIANT_PSEL(pv), .PSEL_PIN(pin), .VBUS_PRESENT(vbus), .OTG_MODE(otg),
    .DETECT_RESULT(dres), .DETECT_DONE(ddone), .DETECT_START(dstart), .CHARGE_PHASE(phase),
    .POWER_GOOD(pg), .THERMAL_REG(therm), .VBAT_BELOW_MINSYS(minsys),
    .INPUT_LIMIT_ACTIVE(lim), .COOL_TEMP(cool), .WARM_TEMP(warm), .TIMER_TICK_IN(tick),
    .SAFETY_TIMER_TICK(ttick), .SAFETY_TIMER_CLEAR(tclr), .BATTERY_SWITCH_ON(swon),
    .BATTERY_SWITCH_RESET_EN(rsten), .VBAT_MV(vbat), .ABS_FLOOR_MV(absf),
    .CHARGE_SETTING_MV(chs), .EFFECTIVE_FLOOR_MV(floor_mv), .CHARGE_VOLTAGE_MV(chv)
  );
  ccs_host h (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (ttick === 1'b1) tcnt++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cwait(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  function automatic logic [7:0] exp_stat();
    logic [2:0] s;
    s = otg ? ccs_pkg::SRC_OTG : !vbus ? ccs_pkg::SRC_NONE : !pv ? dres :
        pin ? ccs_pkg::SRC_SDP : ccs_pkg::SRC_ADPT;
    return {s, phase, pg, therm, minsys};
  endfunction
  function automatic logic [12:0] exp_floor(input logic [1:0] code);
    logic [12:0] s;
    s = vbat + (code == 2'h1 ? ccs_pkg::TRK_MV_200 :
                code == 2'h2 ? ccs_pkg::TRK_MV_250 : ccs_pkg::TRK_MV_300);
    return (code == 2'h0 || absf > s) ? absf : s;
  endfunction
  function automatic logic [12:0] exp_chv(input logic b4);
    return (warm && !b4 && chs > ccs_pkg::WARM_CAP_MV) ? ccs_pkg::WARM_CAP_MV : chs;
  endfunction

  initial begin
    void'($urandom(66));
    repeat (6) @(posedge clk);
    #2;
    rstn = 1'b1;
    cwait(3);
    h.read(CA, rv);
    check(rv, ccs_pkg::CTRL_RESET, "ctrl default");
    check({swon, rsten}, 2'h3, "switch defaults");
    h.read(8'h3c, rv);
    check(rv, ccs_pkg::RDATA_NONE, "unmapped read");
    // Every phase code and every source code but detection result 4, both variants, with ignored status writes
    for (int i = 0; i < 40; i++) begin
      {pg, therm, minsys, pin} = 4'($urandom);
      pv = i[0];
      dres = i[3:1];
      phase = i[5:4] ^ i[1:0];
      vbus = (i % 5 != 4);
      otg = (i % 9 == 8);
      h.write(SA, 8'($urandom));
      h.read(SA, rv);
      check(rv, exp_stat(), "status");
      h.read(CA, rv);
      check(rv, {pv ? pin : 1'b0, ccs_pkg::CTRL_RESET[6:0]}, "ctrl kept");
    end
    {pv, vbus, otg, therm} = 4'h4;
    for (int i = 0; i < 24; i++) begin
      c = (8'($urandom) & 8'h5c) | {6'h00, i[2:1]};
      vbat = 13'($urandom_range(4500, 2500));
      absf = 13'($urandom_range(5400, 3900));
      chs = 13'($urandom_range(4624, 3856));
      warm = i[0];
      h.write(CA, c);
      cwait(2);
      h.read(CA, rv);
      check(rv, c, "ctrl rw");
      check(rsten, c[2], "reset enable");
      check(floor_mv, exp_floor(c[1:0]), "floor");
      check(chv, exp_chv(c[4]), "charge voltage");
    end
    h.write(CA, 8'hcc);
    n = 0;
    repeat (4) begin
      n += (dstart === 1'b1);
      cwait(1);
    end
    check(16'(n), 16'h1, "detect pulse");
    h.read(CA, rv);
    check(rv[7], 1'b1, "detect busy");
    ddone = 1'b1;
    h.write(CA, 8'hcc);
    ddone = 1'b0;
    h.read(CA, rv);
    check(rv[7], 1'b1, "write beats done");
    ddone = 1'b1;
    cwait(1);
    ddone = 1'b0;
    h.read(CA, rv);
    check(rv[7], 1'b0, "detect idle");
    h.write(CA, 8'h24);
    cwait(3);
    check(swon, 1'b0, "switch off now");
    h.write(CA, 8'h0c);
    cwait(3);
    check(swon, 1'b1, "switch back on");
    h.write(CA, 8'h2c);
    cwait(17);
    check(swon, 1'b1, "delay pending");
    cwait(6);
    check(swon, 1'b0, "delay done");
    h.write(CA, 8'h0c);
    h.write(CA, 8'h2c);
    cwait(10);
    h.write(CA, 8'h0c);
    n = 0;
    repeat (20) begin
      n += (swon !== 1'b1);
      cwait(1);
    end
    check(16'(n), 16'h0, "delay cancelled");
    // Modes: plain, slow idle, slow with limit, cool, thermal
    for (int m = 0; m < 5; m++) begin
      h.write(CA, m == 0 ? 8'h0c : 8'h4c);
      {lim, cool, therm} = m == 2 ? 3'h4 : m == 3 ? 3'h2 : (m == 1) ? 3'h0 : 3'h1;
      cwait(2);
      tcnt = 0;
      // Back-to-back pairs so the halving sees adjacent ticks
      repeat (4) begin
        tick = 1'b1;
        cwait(2);
        tick = 1'b0;
        cwait(2);
      end
      check(16'(tcnt), m < 2 ? 16'h8 : 16'h4, "timer ticks");
    end
    {lim, cool, therm} = 3'h0;
    h.write(CA, 8'h13);
    n = 0;
    cmd = 1'b1;
    cwait(1);
    cmd = 1'b0;
    repeat (3) begin
      n += (tclr === 1'b1);
      cwait(1);
    end
    check(16'(n), 16'h1, "timer clear");
    h.read(CA, rv);
    check(rv, ccs_pkg::CTRL_RESET, "reg reset");
    h.write(CA, 8'h2b);
    wdog = 1'b1;
    cwait(1);
    wdog = 1'b0;
    h.read(CA, rv);
    check(rv, (8'h2b & ~ccs_pkg::CTRL_WDOG_MASK) |
              (ccs_pkg::CTRL_RESET & ccs_pkg::CTRL_WDOG_MASK), "watchdog");
    finish_test();
  end
endmodule
`default_nettype wire
